// ---- hdl/dcc_pkg.sv ----
package dcc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W           = 8;
  localparam logic [7:0] OFS_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_SETPOINT_CH1 = 8'h04;
  localparam logic [7:0] OFS_SETPOINT_CH2 = 8'h08;
  localparam logic [7:0] OFS_COUNT_CH1    = 8'h0c;
  localparam logic [7:0] OFS_COUNT_CH2    = 8'h10;
  localparam logic [7:0] OFS_STATUS       = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields (cpu output image)
  // ----------------------------------------------------------------
  localparam int BIT_JOIN_SELECT   = 0;
  localparam int BIT_FUNC_SEL_CH1  = 1;
  localparam int BIT_FUNC_SEL_CH2  = 2;
  localparam int BIT_RELOAD_CH1    = 3;
  localparam int BIT_RELOAD_CH2    = 4;
  localparam int BIT_OUT_CLEAR_CH1 = 5;
  localparam int BIT_OUT_CLEAR_CH2 = 6;
  localparam int BIT_HOLD_CH1      = 7;
  localparam int BIT_HOLD_CH2      = 8;
  localparam int CONTROL_W         = 9;

  // ----------------------------------------------------------------
  // Status register fields (cpu input image)
  // ----------------------------------------------------------------
  localparam int BIT_STAT_OUT_CH1  = 0;
  localparam int BIT_STAT_OUT_CH2  = 1;
  localparam int BIT_STAT_JOINED   = 2;
  localparam int BIT_STAT_UP_CH1   = 3;
  localparam int BIT_STAT_UP_CH2   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CONTROL_W-1:0] CONTROL_RESET  = 9'h000;
  localparam logic [15:0]          SETPOINT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_UP       = 3'b001,
    MODE_PERIODIC = 3'b010,
    MODE_JOINED   = 3'b100
  } dcc_mode_type;

  typedef struct packed {
    logic pulse;
    logic outClear;
    logic countReload;
    logic hold;
  } dcc_ctl_type;

endpackage

// ---- hdl/dcc_core.sv ----
// Notes on behaviour
// - Up-count mode adds one per counted pulse, 16 bits, wrapping to zero.
// - In up-count mode the channel output stays cleared.
// - Periodic mode subtracts one per counted pulse, starting at the setpoint.
// - Periodic mode: on reaching zero, set output and reload setpoint together.
// - Joined mode acts like periodic mode as one 32-bit counter on channel one.
// - Rising output-clear edge clears that channel's output.
// - Output-clear leaves the count untouched.
// - Rising reload edge loads zero (up) or the setpoint (periodic, joined).
// - In down modes a reload edge also clears the output.
// - Hold high ignores pulses and forces the output pin off.
// - Hold low restores the prior output and resumes from the held count.
// - Output-clear and reload keep working while held.
// - Each channel drives true pin, inverted pin and an image status bit.
// - Joined mode uses channel one only; channel two output stays zero.
// - Hardware inputs and cpu image bits are ORed for clear, reload and hold; pulse comes from hardware only.
// - Cpu writes join and function selects; writing alone changes no mode.
// - A new mode starts only on that channel's reload rising edge, or on channel one's when leaving joined mode.
// - Joined mode starts on join select with both reload edges together.
// - While joined, all channel two inputs are ignored.
// - Leaving joined mode: join select low plus reload resets both channels.
// - Function select zero picks periodic, one picks up-count, per channel.
// - A setpoint is taken only on a reload edge or a zero pass.
// - Counts and setpoints are unsigned.
// - Switching a channel to up-count turns its output off.
`timescale 1ns/1ps

module dcc_core (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Hardware control inputs per channel
  input  wire dcc_pkg::dcc_ctl_type hwCh1,
  input  wire dcc_pkg::dcc_ctl_type hwCh2,
  // Register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [31:0]               regRdData,
  // Channel output pins
  output logic                      chanOutCh1,
  output logic                      chanOutNCh1,
  output logic                      chanOutCh2,
  output logic                      chanOutNCh2
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [dcc_pkg::CONTROL_W-1:0] cpuOutputImage;
  logic [15:0]                   setpoint [2];
  logic [15:0]                   cnt [2];
  logic [1:0]                    outState;
  logic                          joined;
  logic [1:0]                    upMode;

  always_ff @(posedge clk) begin
    if (rst) begin
      cpuOutputImage <= dcc_pkg::CONTROL_RESET;
      setpoint[0]    <= dcc_pkg::SETPOINT_RESET;
      setpoint[1]    <= dcc_pkg::SETPOINT_RESET;
    end else if (regWr) begin
      unique case (regAddr)
        dcc_pkg::OFS_CONTROL:      cpuOutputImage <= regWrData[dcc_pkg::CONTROL_W-1:0];
        dcc_pkg::OFS_SETPOINT_CH1: setpoint[0] <= regWrData[15:0];
        dcc_pkg::OFS_SETPOINT_CH2: setpoint[1] <= regWrData[15:0];
        default: ;
      endcase
    end
  end

  logic [31:0] next_rdData;
  always_comb begin
    next_rdData = 32'h0000_0000;
    unique case (regAddr)
      dcc_pkg::OFS_CONTROL:      next_rdData[dcc_pkg::CONTROL_W-1:0] = cpuOutputImage;
      dcc_pkg::OFS_SETPOINT_CH1: next_rdData[15:0] = setpoint[0];
      dcc_pkg::OFS_SETPOINT_CH2: next_rdData[15:0] = setpoint[1];
      dcc_pkg::OFS_COUNT_CH1:    next_rdData[15:0] = cnt[0];
      dcc_pkg::OFS_COUNT_CH2:    next_rdData[15:0] = cnt[1];
      dcc_pkg::OFS_STATUS: begin
        next_rdData[dcc_pkg::BIT_STAT_OUT_CH1] = chanOutCh1;
        next_rdData[dcc_pkg::BIT_STAT_OUT_CH2] = chanOutCh2;
        next_rdData[dcc_pkg::BIT_STAT_JOINED]  = joined;
        next_rdData[dcc_pkg::BIT_STAT_UP_CH1]  = upMode[0];
        next_rdData[dcc_pkg::BIT_STAT_UP_CH2]  = upMode[1];
      end
      default: next_rdData = 32'h0000_0000;
    endcase
  end

  // Read data is only valid in the cycle after the strobe; zero otherwise.
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRd ? next_rdData : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  dcc_pkg::dcc_ctl_type syncA [2];
  dcc_pkg::dcc_ctl_type syncB [2];
  dcc_pkg::dcc_ctl_type merged [2];
  dcc_pkg::dcc_ctl_type mergedPrev [2];
  logic [1:0]           pulseRise;
  logic [1:0]           clearRise;
  logic [1:0]           reloadRise;
  logic [1:0]           holdLvl;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncA[0] <= '0;
      syncA[1] <= '0;
      syncB[0] <= '0;
      syncB[1] <= '0;
    end else begin
      syncA[0] <= hwCh1;
      syncA[1] <= hwCh2;
      syncB[0] <= syncA[0];
      syncB[1] <= syncA[1];
    end
  end

  // Cpu bits carry no pulse source: counting pulses come from the process side only.
  always_comb begin
    merged[0].pulse       = syncB[0].pulse;
    merged[1].pulse       = syncB[1].pulse;
    merged[0].outClear    = syncB[0].outClear | cpuOutputImage[dcc_pkg::BIT_OUT_CLEAR_CH1];
    merged[1].outClear    = syncB[1].outClear | cpuOutputImage[dcc_pkg::BIT_OUT_CLEAR_CH2];
    merged[0].countReload = syncB[0].countReload | cpuOutputImage[dcc_pkg::BIT_RELOAD_CH1];
    merged[1].countReload = syncB[1].countReload | cpuOutputImage[dcc_pkg::BIT_RELOAD_CH2];
    merged[0].hold        = syncB[0].hold | cpuOutputImage[dcc_pkg::BIT_HOLD_CH1];
    merged[1].hold        = syncB[1].hold | cpuOutputImage[dcc_pkg::BIT_HOLD_CH2];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mergedPrev[0] <= '0;
      mergedPrev[1] <= '0;
    end else begin
      mergedPrev[0] <= merged[0];
      mergedPrev[1] <= merged[1];
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pulseRise[i]  = merged[i].pulse & ~mergedPrev[i].pulse;
      clearRise[i]  = merged[i].outClear & ~mergedPrev[i].outClear;
      reloadRise[i] = merged[i].countReload & ~mergedPrev[i].countReload;
      holdLvl[i]    = merged[i].hold;
    end
  end

  // ----------------------------------------------------------------
  // Counting engine
  // ----------------------------------------------------------------
  function automatic logic [31:0] down_step(input logic [31:0] value, input logic [31:0] preset);
    // A count of one steps to zero, which is taken as reaching the end: reload at once.
    // A count of zero comes from reset or a zero setpoint; the next pulse loads the preset.
    down_step = (value <= 32'h0000_0001) ? preset : value - 32'h0000_0001;
  endfunction

  logic [15:0] next_cnt [2];
  logic [1:0]  next_outState;
  logic        next_joined;
  logic [1:0]  next_upMode;
  logic [31:0] joinCount;
  logic [31:0] joinPreset;
  logic [31:0] joinStep;

  assign joinCount  = {cnt[0], cnt[1]};
  assign joinPreset = {setpoint[0], setpoint[1]};
  assign joinStep   = down_step(joinCount, joinPreset);

  always_comb begin
    next_cnt[0]   = cnt[0];
    next_cnt[1]   = cnt[1];
    next_outState = outState;
    next_joined   = joined;
    next_upMode   = upMode;
    if (joined) begin
      // Channel two inputs are not looked at while joined.
      if (reloadRise[0]) begin
        if (!cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT]) begin
          next_joined    = 1'b0;
          next_upMode[0] = cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH1];
          next_upMode[1] = cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH2];
          next_cnt[0]    = next_upMode[0] ? 16'h0000 : setpoint[0];
          next_cnt[1]    = next_upMode[1] ? 16'h0000 : setpoint[1];
        end else begin
          {next_cnt[0], next_cnt[1]} = joinPreset;
        end
        next_outState = 2'b00;
      end else begin
        if (pulseRise[0] && !holdLvl[0]) begin
          {next_cnt[0], next_cnt[1]} = joinStep;
          if (joinCount == 32'h0000_0001) begin
            next_outState[0] = 1'b1;
          end
        end
        if (clearRise[0]) begin
          next_outState[0] = 1'b0;
        end
      end
      next_outState[1] = 1'b0;
    end else if (cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT] && reloadRise[0] && reloadRise[1]) begin
      next_joined                = 1'b1;
      next_upMode                = 2'b00;
      {next_cnt[0], next_cnt[1]} = joinPreset;
      next_outState              = 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reloadRise[i]) begin
          next_upMode[i]   = cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH1 + i];
          next_cnt[i]      = next_upMode[i] ? 16'h0000 : setpoint[i];
          next_outState[i] = 1'b0;
        end else begin
          if (pulseRise[i] && !holdLvl[i]) begin
            if (upMode[i]) begin
              next_cnt[i] = cnt[i] + 16'h0001;
            end else begin
              next_cnt[i] = 16'(down_step({16'h0000, cnt[i]}, {16'h0000, setpoint[i]}));
              if (cnt[i] == 16'h0001) begin
                next_outState[i] = 1'b1;
              end
            end
          end
          if (clearRise[i]) begin
            next_outState[i] = 1'b0;
          end
        end
        if (next_upMode[i]) begin
          next_outState[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt[0]   <= 16'h0000;
      cnt[1]   <= 16'h0000;
      outState <= 2'b00;
      joined   <= 1'b0;
      upMode   <= 2'b00;
    end else begin
      cnt[0]   <= next_cnt[0];
      cnt[1]   <= next_cnt[1];
      outState <= next_outState;
      joined   <= next_joined;
      upMode   <= next_upMode;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // The latched state survives a hold; only the pins are masked.
  always_ff @(posedge clk) begin
    if (rst) begin
      chanOutCh1  <= 1'b0;
      chanOutNCh1 <= 1'b1;
      chanOutCh2  <= 1'b0;
      chanOutNCh2 <= 1'b1;
    end else begin
      chanOutCh1  <= next_outState[0] & ~holdLvl[0];
      chanOutNCh1 <= ~(next_outState[0] & ~holdLvl[0]);
      chanOutCh2  <= next_outState[1] & ~holdLvl[1] & ~next_joined;
      chanOutNCh2 <= ~(next_outState[1] & ~holdLvl[1] & ~next_joined);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_up_count_step: assert property (@(posedge clk) disable iff (rst)
    (!joined && upMode[0] && pulseRise[0] && !reloadRise[0] && !holdLvl[0])
      |=> (cnt[0] == $past(cnt[0]) + 16'h0001))
    else $error("up count did not step by one");

  chk_up_out_off: assert property (@(posedge clk) disable iff (rst)
    (!joined && upMode[0]) |=> !chanOutCh1)
    else $error("output set in up-count mode");

  chk_down_step: assert property (@(posedge clk) disable iff (rst)
    (!joined && !upMode[0] && pulseRise[0] && !reloadRise[0] && !holdLvl[0] && cnt[0] > 16'h0001)
      |=> (cnt[0] == $past(cnt[0]) - 16'h0001))
    else $error("periodic count did not step down by one");

  chk_zero_reload: assert property (@(posedge clk) disable iff (rst)
    (!joined && !upMode[0] && pulseRise[0] && !reloadRise[0] && !holdLvl[0] && !clearRise[0]
      && cnt[0] == 16'h0001) |=> (cnt[0] == $past(setpoint[0]) && outState[0]))
    else $error("zero pass did not reload and set output");

  chk_clear_keeps: assert property (@(posedge clk) disable iff (rst)
    (clearRise[0] && !pulseRise[0] && !reloadRise[0]) |=> (cnt[0] == $past(cnt[0]) && !outState[0]))
    else $error("output clear changed the count or left output set");

  chk_hold_pin_off: assert property (@(posedge clk) disable iff (rst)
    holdLvl[0] |=> !chanOutCh1)
    else $error("pin active while held");

  chk_joined_ch2_off: assert property (@(posedge clk) disable iff (rst)
    joined |-> !chanOutCh2)
    else $error("channel two output set while joined");

  chk_join_entry: assert property (@(posedge clk) disable iff (rst)
    (!joined && cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT] && reloadRise[0] && reloadRise[1])
      |=> (joined && joinCount == $past(joinPreset)))
    else $error("join entry did not load the 32-bit setpoint");

  chk_reload_wins: assert property (@(posedge clk) disable iff (rst)
    (!joined && reloadRise[0] && !cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH1]
      && !(cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT] && reloadRise[1]))
      |=> (cnt[0] == $past(setpoint[0]) && !upMode[0]))
    else $error("reload did not take priority");

  chk_up_step_two: assert property (@(posedge clk) disable iff (rst)
    (!joined && upMode[1] && pulseRise[1] && !reloadRise[1] && !holdLvl[1])
      |=> (cnt[1] == $past(cnt[1]) + 16'h0001))
    else $error("channel two up count did not step by one");

  chk_up_off_two: assert property (@(posedge clk) disable iff (rst)
    (!joined && upMode[1]) |=> !chanOutCh2)
    else $error("channel two output set in up-count mode");

  chk_inverted_pins: assert property (@(posedge clk) disable iff (rst)
    (chanOutNCh1 != chanOutCh1) && (chanOutNCh2 != chanOutCh2))
    else $error("inverted pin does not mirror its true pin");

  chk_hold_count_one: assert property (@(posedge clk) disable iff (rst)
    (!joined && holdLvl[0] && !reloadRise[0]) |=> (cnt[0] == $past(cnt[0])))
    else $error("channel one counted while held");

  chk_hold_count_two: assert property (@(posedge clk) disable iff (rst)
    (!joined && holdLvl[1] && !reloadRise[1]) |=> (cnt[1] == $past(cnt[1])))
    else $error("channel two counted while held");

  chk_reload_up_two: assert property (@(posedge clk) disable iff (rst)
    (!joined && reloadRise[1] && cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH2]
      && !(cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT] && reloadRise[0]))
      |=> (cnt[1] == 16'h0000 && upMode[1]))
    else $error("up-count reload did not clear the count");

  chk_mode_waits: assert property (@(posedge clk) disable iff (rst)
    (!joined && !reloadRise[0]) |=> (upMode[0] == $past(upMode[0])))
    else $error("channel one mode changed without a reload edge");

  chk_setpoint_waits: assert property (@(posedge clk) disable iff (rst)
    (!joined && !reloadRise[1] && !pulseRise[1]) |=> (cnt[1] == $past(cnt[1])))
    else $error("channel two count changed without a pulse or reload");

  chk_joined_step: assert property (@(posedge clk) disable iff (rst)
    (joined && pulseRise[0] && !reloadRise[0] && !holdLvl[0] && joinCount > 32'h0000_0001)
      |=> (joinCount == $past(joinCount) - 32'h0000_0001))
    else $error("joined count did not step down by one");

  chk_joined_ignores: assert property (@(posedge clk) disable iff (rst)
    (joined && !reloadRise[0] && !pulseRise[0]) |=> (joinCount == $past(joinCount)))
    else $error("joined count moved without a channel one event");

  chk_join_leave: assert property (@(posedge clk) disable iff (rst)
    (joined && reloadRise[0] && !cpuOutputImage[dcc_pkg::BIT_JOIN_SELECT])
      |=> (!joined && upMode[0] == $past(cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH1])
        && upMode[1] == $past(cpuOutputImage[dcc_pkg::BIT_FUNC_SEL_CH2])))
    else $error("leaving joined mode did not follow the function selects");

endmodule

// ---- tb/dcc_cpu_model.sv ----
`timescale 1ns/1ps

module dcc_cpu_model (
  // Clock
  input  wire logic        clk,
  // Register port towards the counter
  output logic [7:0]       regAddr,
  output logic [31:0]      regWrData,
  output logic             regWr,
  output logic             regRd
);
  logic [31:0] ctl;

  initial begin
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    ctl = 32'h0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Writes leave inverted data and reads an inverted address on the bus, so stale values are never mistaken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
  endtask

  // ----------------------------------------------------------------
  // Control image
  // ----------------------------------------------------------------
  // Mode and hold bits go out on their own; they must not restart anything.
  task automatic ctlSet(input logic [31:0] v);
    ctl = v;
    wr(dcc_pkg::OFS_CONTROL, ctl);
    repeat (4) @(posedge clk);
  endtask

  // Reload and clear act on edges, so the bits are raised and dropped again.
  // Joining needs both reload bits within one and the same write.
  task automatic ctlEdge(input logic [31:0] b);
    wr(dcc_pkg::OFS_CONTROL, ctl | b);
    wr(dcc_pkg::OFS_CONTROL, ctl);
    repeat (4) @(posedge clk);
  endtask
endmodule

// ---- tb/dcc_core_tb.sv ----
`timescale 1ns/1ps

module dcc_core_tb;
  localparam logic [7:0] CT = dcc_pkg::OFS_CONTROL;
  localparam logic [7:0] S1 = dcc_pkg::OFS_SETPOINT_CH1;
  localparam logic [7:0] S2 = dcc_pkg::OFS_SETPOINT_CH2;
  localparam logic [7:0] C1 = dcc_pkg::OFS_COUNT_CH1;
  localparam logic [7:0] C2 = dcc_pkg::OFS_COUNT_CH2;
  localparam logic [7:0] ST = dcc_pkg::OFS_STATUS;

  logic                 clk;
  logic                 rst;
  dcc_pkg::dcc_ctl_type hw1;
  dcc_pkg::dcc_ctl_type hw2;
  logic [7:0]           regAddr;
  logic [31:0]          regWrData;
  logic                 regWr;
  logic                 regRd;
  logic [31:0]          regRdData;
  logic                 chanOutCh1;
  logic                 chanOutNCh1;
  logic                 chanOutCh2;
  logic                 chanOutNCh2;
  logic                 rdPend;
  logic [63:0]          expQ[$];
  logic [63:0]          e;
  logic [31:0]          seed;
  logic [31:0]          n;
  logic [31:0]          r;
  int                   errTotal;
  int                   nTests;

  dcc_cpu_model cpu (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd));

  dcc_core uut (
    .clk(clk), .rst(rst), .hwCh1(hw1), .hwCh2(hw2),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .chanOutCh1(chanOutCh1), .chanOutNCh1(chanOutNCh1), .chanOutCh2(chanOutCh2), .chanOutNCh2(chanOutNCh2)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    expQ.push_back({m, x});
    cpu.rd(a);
  endtask

  // Pins are looked at just after the edge, once its updates have landed.
  task automatic pins(input logic [3:0] x);
    #1;
    chk({28'h0, chanOutCh1, chanOutNCh1, chanOutCh2, chanOutNCh2}, {28'h0, x});
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) rdPend <= regRd;
  always @(negedge clk) begin
    if (rdPend === 1'b1) begin
      e = expQ.pop_front();
      chk(regRdData & e[63:32], e[31:0]);
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Each level is held long enough to pass the input synchronisers.
  task automatic hwp(input int ch, input int b, input logic [31:0] cnt);
    repeat (cnt) begin
      @(posedge clk);
      if (ch == 1) hw1[b] <= 1'b1;
      else hw2[b] <= 1'b1;
      repeat (2) @(posedge clk);
      if (ch == 1) hw1[b] <= 1'b0;
      else hw2[b] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // Levels settle through both synchroniser stages before the task returns.
  task automatic hwl(input int ch, input int b, input logic v);
    @(posedge clk);
    if (ch == 1) hw1[b] <= v;
    else hw2[b] <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    endOfTest();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hw1 = '0;
    hw2 = '0;
    rdPend = 1'b0;
    errTotal = 0;
    nTests = 0;
    seed = 32'd65752;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(CT, 32'h0);
    rd(ST, 32'h0);
    rd(C1, 32'h0);
    rd(8'h18, 32'h0);
    pins(4'b0101);
    $display("reset test done");
    cpu.wr(S1, 32'h3);
    cpu.ctlEdge(32'h8);
    rd(C1, 32'h3);
    hwp(1, 3, 2);
    rd(C1, 32'h1);
    hwp(1, 3, 1);
    rd(C1, 32'h3);
    rd(ST, 32'h1, 32'h1);
    pins(4'b1001);
    $display("periodic test done");
    cpu.ctlSet(32'h80);
    pins(4'b0101);
    hwp(1, 3, 1);
    rd(C1, 32'h3);
    cpu.ctlSet(32'h0);
    pins(4'b1001);
    hwp(1, 2, 1);
    pins(4'b0101);
    rd(C1, 32'h3);
    hwp(1, 3, 4);
    pins(4'b1001);
    rd(C1, 32'h2);
    hwl(1, 0, 1'b1);
    pins(4'b0101);
    hwp(1, 1, 1);
    hwl(1, 0, 1'b0);
    pins(4'b0101);
    rd(C1, 32'h3);
    $display("hold and clear test done");
    hwp(1, 3, 3);
    pins(4'b1001);
    cpu.ctlSet(32'h6);
    rd(ST, 32'h0, 32'h18);
    r = xs();
    cpu.wr(S2, r);
    rd(S2, {16'h0000, r[15:0]});
    rd(C2, 32'h0);
    cpu.ctlEdge(32'h18);
    pins(4'b0101);
    rd(ST, 32'h18, 32'h18);
    rd(C2, 32'h0);
    n = (xs() % 32'd5) + 32'd1;
    hwp(2, 3, n);
    rd(C2, n);
    hwp(2, 2, 1);
    rd(C2, n);
    hwl(2, 0, 1'b1);
    hwp(2, 3, 1);
    rd(C2, n);
    hwl(2, 0, 1'b0);
    hwp(1, 3, n);
    rd(C1, n);
    pins(4'b0101);
    $display("up count test done");
    cpu.wr(S1, 32'h1);
    cpu.wr(S2, 32'h0);
    cpu.ctlSet(32'h5);
    rd(ST, 32'h0, 32'h4);
    cpu.ctlEdge(32'h18);
    rd(ST, 32'h4, 32'h4);
    rd(C1, 32'h1);
    rd(C2, 32'h0);
    hwp(2, 3, 2);
    hwp(2, 1, 1);
    rd(C2, 32'h0);
    hwp(1, 3, 1);
    rd(C1, 32'h0);
    rd(C2, 32'hffff);
    pins(4'b0101);
    cpu.ctlSet(32'h4);
    cpu.ctlEdge(32'h8);
    rd(ST, 32'h10, 32'h1c);
    rd(C1, 32'h1);
    rd(C2, 32'h0);
    $display("joined test done");
    repeat (4) @(posedge clk);
    endOfTest();
  end
endmodule
